/* File: design/osp_pkg.sv */
package osp_pkg;

  // register map of the plain register port
  localparam logic [3:0] OSP_POWER_CONTROL_REGISTER_ADDR   = 4'h0;
  localparam logic [3:0] OSP_STATUS_ADDR = 4'h1;
  localparam int         OSP_DATA_W      = 8;

  // power control register fields and reset value
  localparam int         OSP_IDLE_BIT   = 0;
  localparam int         OSP_PD_BIT     = 1;
  localparam int         OSP_SLOW_BIT   = 4;
  localparam logic [7:0] OSP_POWER_CONTROL_REGISTER_RESET = 8'h00;
  localparam logic [7:0] OSP_SLOW_CLR   = 8'hEF;

  // status register fields
  localparam int OSP_ST_RC_BIT    = 0;
  localparam int OSP_ST_RST_BIT   = 1;
  localparam int OSP_ST_OK_BIT    = 2;
  localparam int OSP_ST_PD_BIT    = 3;
  localparam int OSP_ST_WAKE_BIT  = 4;

  // timing: reference clock 10 MHz, stabilisation 1 ms
  localparam int OSP_CLK_KHZ       = 10000;
  localparam int OSP_STAB_TIME_US  = 1000;
  localparam int OSP_STAB_CYCLES   = (OSP_STAB_TIME_US * OSP_CLK_KHZ + 999) / 1000;

  // slow-down divides the internal clock by this figure
  localparam int         OSP_SLOW_DIV  = 32;
  localparam logic [4:0] OSP_SLOW_LAST = 5'h1F;

  // rc ticks per comparison window
  localparam int OSP_CMP_WIN = 16;

  typedef enum logic [2:0] {
    OSP_FAIL,
    OSP_STAB,
    OSP_RUN,
    OSP_PD,
    OSP_WAKE_WAIT,
    OSP_WAKE_STAB
  } osp_state_t;

endpackage

/* File: design/osp_cmp_if.sv */
`timescale 1ns/1ps
interface osp_cmp_if;
  logic halt;
  logic main_ok;

  modport mon (
    input  halt,
    output main_ok
  );
  modport ctl (
    output halt,
    input  main_ok
  );
endinterface

/* File: design/osp_freq_cmp.sv */
`timescale 1ns/1ps
// counts main oscillator ticks over a window of rc ticks; main is good
// only when it produced more ticks than the rc oscillator did
module osp_freq_cmp
  import osp_pkg::*;
#(
  parameter int WIN = OSP_CMP_WIN
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic rc_tick,
  input  wire logic main_tick,
  osp_cmp_if.mon    cmp
);
  localparam int RW = $clog2(WIN);
  localparam int MW = RW + 2;
  localparam logic [RW-1:0] RC_LAST  = RW'(WIN - 1);
  localparam logic [MW-1:0] MAIN_MAX = {MW{1'b1}};
  localparam logic [MW-1:0] MAIN_MIN = MW'(WIN);

  logic [RW-1:0] rc_cnt;
  logic [MW-1:0] main_cnt;
  logic          win_end;

  assign win_end = rc_tick && (rc_cnt == RC_LAST);

  always_ff @(posedge ref_clk) begin
    if (rst || cmp.halt) begin
      rc_cnt <= '0;
    end else if (rc_tick) begin
      rc_cnt <= rc_cnt + RW'(1);
    end
  end

  // saturating, so a very fast main clock never wraps into a false fail
  always_ff @(posedge ref_clk) begin
    if (rst || cmp.halt || win_end) begin
      main_cnt <= '0;
    end else if (main_tick && main_cnt != MAIN_MAX) begin
      main_cnt <= main_cnt + MW'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || cmp.halt) begin
      cmp.main_ok <= 1'b0;
    end else if (win_end) begin
      cmp.main_ok <= (main_cnt > MAIN_MIN);
    end
  end
endmodule

/* File: design/osc_supervisor_power_modes.sv */
// Functional notes
// - main clock slower than rc: run from rc and hold reset
// - main faster again: keep reset about 1 ms more, then release
// - after power-on the reset sequence runs from rc, same switch-over
// - wake-up interrupt starts only once main clock runs at nominal rate
// - power-down halts both oscillators; wake-up restarts both
// - after wake, main above rc, wait about 1 ms before executing
// - supervisor always active, no control disables it; the code pauses the comparator in power-down
// - idle stops cpu clock, peripherals keep running
// - value 01 enters idle; enabled interrupt or reset leaves it
// - slow-down divides cpu and peripheral clock by 32
// - value 10 enters slow-down; mask 0EF or reset leaves it
// - value 02 enters power-down; reset or wake pulse leaves it
// - ram and register contents kept through power-down
`timescale 1ns/1ps
module osc_supervisor_power_modes
  import osp_pkg::*;
#(
  parameter int STAB_CYCLES = OSP_STAB_CYCLES,
  parameter int CMP_WIN     = OSP_CMP_WIN
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic                  rc_tick,
  input  wire logic                  main_tick,
  input  wire logic                  external_wake_pin_n,
  input  wire logic                  irq_pending,
  input  wire logic [3:0]            addr,
  input  wire logic [OSP_DATA_W-1:0] wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output logic      [OSP_DATA_W-1:0] rdata,
  output logic                       clk_sel_rc,
  output logic                       sys_reset,
  output logic                       rc_osc_run,
  output logic                       main_osc_run,
  output logic                       cpu_clk_en,
  output logic                       periph_clk_en,
  output logic                       wake_irq
);
  localparam int CW = $clog2(STAB_CYCLES + 1);
  localparam logic [CW-1:0] STAB_LAST = CW'(STAB_CYCLES - 1);

  osp_state_t           state;
  osp_state_t           next_state;
  logic [CW-1:0]        stab_cnt;
  logic [4:0]           div_cnt;
  logic [7:0]           power_control_register;
  logic                 power_control_register_wr;
  logic                 slow_pulse;
  logic                 base_en;
  logic                 stab_done;
  logic                 main_ok;

  osp_cmp_if cmp ();

  osp_freq_cmp #(
    .WIN (CMP_WIN)
  ) u_cmp (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .rc_tick   (rc_tick),
    .main_tick (main_tick),
    .cmp       (cmp.mon)
  );

  // the comparator is only paused while its oscillators are stopped;
  // there is deliberately no software path to this signal
  assign cmp.halt = (state == OSP_PD);
  assign main_ok  = cmp.main_ok;

  function automatic logic in_stab(input osp_state_t s);
    in_stab = (s == OSP_STAB) || (s == OSP_WAKE_STAB);
  endfunction

  assign stab_done = (stab_cnt == STAB_LAST);
  assign power_control_register_wr   = wr && (addr == OSP_POWER_CONTROL_REGISTER_ADDR);

  // ---------------------------------------------------------------
  // supervision state machine
  always_comb begin
    next_state = state;
    case (state)
      OSP_FAIL: begin
        if (main_ok) begin
          next_state = OSP_STAB;
        end
      end
      OSP_STAB: begin
        if (!main_ok) begin
          next_state = OSP_FAIL;
        end else if (stab_done) begin
          next_state = OSP_RUN;
        end
      end
      OSP_RUN: begin
        if (!main_ok) begin
          next_state = OSP_FAIL;
        end else if (power_control_register[OSP_PD_BIT]) begin
          next_state = OSP_PD;
        end
      end
      OSP_PD: begin
        if (!external_wake_pin_n) begin
          next_state = OSP_WAKE_WAIT;
        end
      end
      OSP_WAKE_WAIT: begin
        if (main_ok) begin
          next_state = OSP_WAKE_STAB;
        end
      end
      OSP_WAKE_STAB: begin
        if (!main_ok) begin
          next_state = OSP_WAKE_WAIT;
        end else if (stab_done) begin
          next_state = OSP_RUN;
        end
      end
      default: begin
        next_state = OSP_FAIL;
      end
    endcase
  end

  // power-on starts in the fail state so the rc clock drives reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= OSP_FAIL;
    end else begin
      state <= next_state;
    end
  end

  // a drop of main_ok restarts the full stabilisation time
  always_ff @(posedge ref_clk) begin
    if (rst || !in_stab(state) || !main_ok) begin
      stab_cnt <= '0;
    end else if (!stab_done) begin
      stab_cnt <= stab_cnt + CW'(1);
    end
  end

  // ---------------------------------------------------------------
  // clock source, reset and oscillator enables
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clk_sel_rc <= 1'b1;
      sys_reset  <= 1'b1;
    end else begin
      clk_sel_rc <= (next_state == OSP_FAIL) || (next_state == OSP_WAKE_WAIT);
      sys_reset  <= (next_state == OSP_FAIL) || (next_state == OSP_STAB);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rc_osc_run   <= 1'b1;
      main_osc_run <= 1'b1;
    end else begin
      rc_osc_run   <= (next_state != OSP_PD);
      main_osc_run <= (next_state != OSP_PD);
    end
  end

  // wake interrupt fires once, only at the end of a wake stabilisation (OSP_WAKE_STAB to OSP_RUN)
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wake_irq <= 1'b0;
    end else begin
      wake_irq <= (state == OSP_WAKE_STAB) && (next_state == OSP_RUN);
    end
  end

  // ---------------------------------------------------------------
  // power control register; a software write wins over a hardware clear
  // nothing but a write, reset or exit clear touches it, so power-down keeps it
  always_ff @(posedge ref_clk) begin
    if (rst || sys_reset) begin
      power_control_register <= OSP_POWER_CONTROL_REGISTER_RESET;
    end else if (power_control_register_wr) begin
      power_control_register <= wdata;
    end else begin
      if (irq_pending) begin
        power_control_register[OSP_IDLE_BIT] <= 1'b0;
      end
      if (state == OSP_PD && next_state == OSP_WAKE_WAIT) begin
        power_control_register[OSP_PD_BIT] <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // slow-down divider; free running so the pulse spacing is exact
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 5'h01;
    end
  end

  assign slow_pulse = (div_cnt == OSP_SLOW_LAST);
  assign base_en    = power_control_register[OSP_SLOW_BIT] ? slow_pulse : 1'b1;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cpu_clk_en    <= 1'b0;
      periph_clk_en <= 1'b0;
    end else begin
      cpu_clk_en    <= (state == OSP_RUN) && base_en &&
                       !power_control_register[OSP_IDLE_BIT] &&
                       !power_control_register[OSP_PD_BIT];
      periph_clk_en <= (state == OSP_RUN) && base_en &&
                       !power_control_register[OSP_PD_BIT];
    end
  end

  // ---------------------------------------------------------------
  // read port, data valid in the cycle after rd
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata <= '0;
    end else if (rd) begin
      case (addr)
        OSP_POWER_CONTROL_REGISTER_ADDR: begin
          rdata <= power_control_register;
        end
        OSP_STATUS_ADDR: begin
          rdata                  <= '0;
          rdata[OSP_ST_RC_BIT]   <= clk_sel_rc;
          rdata[OSP_ST_RST_BIT]  <= sys_reset;
          rdata[OSP_ST_OK_BIT]   <= main_ok;
          rdata[OSP_ST_PD_BIT]   <= (state == OSP_PD);
          rdata[OSP_ST_WAKE_BIT] <= (state == OSP_WAKE_WAIT) || (state == OSP_WAKE_STAB);
        end
        default: begin
          rdata <= '0;
        end
      endcase
    end else begin
      rdata <= '0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  sequence stab_full_s;
    in_stab($past(state)) && ($past(stab_cnt) == STAB_LAST);
  endsequence

  sequence pd_wake_s;
    (state == OSP_PD) && !external_wake_pin_n;
  endsequence

  fail_hold_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (state == OSP_FAIL) && $past(state == OSP_FAIL) |-> clk_sel_rc && sys_reset
  ) else $error("fail state without rc clock and reset");

  stab_release_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    $fell(sys_reset) |-> stab_full_s
  ) else $error("reset released without full stabilisation");

  por_rc_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    $past(rst) |-> clk_sel_rc && sys_reset && (state == OSP_FAIL)
  ) else $error("power-on reset not on rc clock");

  wake_irq_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    wake_irq |-> $past(main_ok) && ($past(state) == OSP_WAKE_STAB)
  ) else $error("wake interrupt before nominal clock");

  pd_osc_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    pd_wake_s |=> ##1 rc_osc_run && main_osc_run
  ) else $error("oscillators not restarted on wake");

  pd_stop_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (state == OSP_PD) && $past(state == OSP_PD) |-> !rc_osc_run && !main_osc_run
  ) else $error("oscillators running in power-down");

  wake_delay_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (state == OSP_RUN) && $past(state == OSP_WAKE_STAB) |->
      $past(stab_cnt) == STAB_LAST
  ) else $error("execution resumed before wake delay");

  sup_active_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    cmp.halt |-> (state == OSP_PD) && !rc_osc_run
  ) else $error("supervisor paused outside power-down");

  idle_clk_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    $past(state == OSP_RUN && power_control_register == 8'h01) |->
      !cpu_clk_en && periph_clk_en
  ) else $error("idle clock gating wrong");

  idle_exit_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    power_control_register[OSP_IDLE_BIT] && irq_pending && !power_control_register_wr && !sys_reset |=>
      !power_control_register[OSP_IDLE_BIT]
  ) else $error("interrupt did not end idle");

  slow_div_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    periph_clk_en && $past(power_control_register[OSP_SLOW_BIT]) |->
      $past(div_cnt) == OSP_SLOW_LAST
  ) else $error("slow-down enable not every 32nd cycle");

  slow_clear_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    power_control_register_wr && !sys_reset && (wdata == (power_control_register & OSP_SLOW_CLR)) |=>
      !power_control_register[OSP_SLOW_BIT]
  ) else $error("mask write did not leave slow-down");

  slow_idle_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (power_control_register == 8'h11) && irq_pending && !power_control_register_wr && !sys_reset |=>
      power_control_register == 8'h10
  ) else $error("combined mode exit wrong");

  pd_entry_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (state == OSP_RUN) && main_ok && power_control_register[OSP_PD_BIT] |=>
      state == OSP_PD ##1 !cpu_clk_en && !periph_clk_en
  ) else $error("power-down not entered");

  pd_retain_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (state == OSP_PD) && !power_control_register_wr && external_wake_pin_n |=>
      $stable(power_control_register)
  ) else $error("register changed during power-down");

  pd_autoclr_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (pd_wake_s and !power_control_register_wr) |=> !power_control_register[OSP_PD_BIT]
  ) else $error("power-down bit not cleared on wake");

endmodule

/* File: bench/osp_osc_model.sv */
`timescale 1ns/1ps
// stands in for the main crystal, the rc oscillator and the wake pin;
// tick rates are scaled so that one comparison window stays short
module osp_osc_model #(
  parameter int RC_DIV   = 4,
  parameter int FAST_DIV = 2,
  parameter int SLOW_DIV = 8
) (
  input  wire logic ref_clk,
  input  wire logic rc_osc_run,
  input  wire logic main_osc_run,
  input  wire logic main_slow,
  input  wire logic wake_req,
  output logic      rc_tick,
  output logic      main_tick,
  output logic      external_wake_pin_n
);
  int rc_cnt   = 0;
  int main_cnt = 0;
  int main_div;

  assign main_div = main_slow ? SLOW_DIV : FAST_DIV;
  // pin has a pull-up, the request pulls it low only while it is held
  assign external_wake_pin_n = !wake_req;

  // a halted oscillator gives no ticks and restarts from phase zero
  always @(posedge ref_clk) begin
    if (!rc_osc_run) begin
      rc_cnt <= 0;
      rc_tick <= 1'b0;
    end else begin
      rc_cnt <= (rc_cnt >= RC_DIV - 1) ? 0 : rc_cnt + 1;
      rc_tick <= (rc_cnt >= RC_DIV - 1);
    end
  end

  always @(posedge ref_clk) begin
    if (!main_osc_run) begin
      main_cnt <= 0;
      main_tick <= 1'b0;
    end else begin
      main_cnt <= (main_cnt >= main_div - 1) ? 0 : main_cnt + 1;
      main_tick <= (main_cnt >= main_div - 1);
    end
  end
endmodule

/* File: bench/osc_supervisor_power_modes_tb_top.sv */
`timescale 1ns/1ps
module osc_supervisor_power_modes_tb_top
  import osp_pkg::*;
;
  localparam int STAB = 20;
  localparam int WIN  = 4;

  logic                  ref_clk;
  logic                  rst;
  logic                  wake_req;
  logic                  main_slow;
  logic                  irq_pending;
  logic [3:0]            addr;
  logic [OSP_DATA_W-1:0] wdata;
  logic                  wr;
  logic                  rd;
  logic [OSP_DATA_W-1:0] rdata;
  logic                  clk_sel_rc;
  logic                  sys_reset;
  logic                  rc_osc_run;
  logic                  main_osc_run;
  logic                  cpu_clk_en;
  logic                  periph_clk_en;
  logic                  wake_irq;
  logic                  rc_tick;
  logic                  main_tick;
  logic                  external_wake_pin_n;
  int                    num_errors;
  int                    num_checks;

  osc_supervisor_power_modes #(.STAB_CYCLES(STAB), .CMP_WIN(WIN)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .rc_tick(rc_tick), .main_tick(main_tick),
    .external_wake_pin_n(external_wake_pin_n), .irq_pending(irq_pending),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .clk_sel_rc(clk_sel_rc), .sys_reset(sys_reset), .rc_osc_run(rc_osc_run),
    .main_osc_run(main_osc_run), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .wake_irq(wake_irq)
  );

  osp_osc_model osc_u (
    .ref_clk(ref_clk), .rc_osc_run(rc_osc_run), .main_osc_run(main_osc_run),
    .main_slow(main_slow), .wake_req(wake_req), .rc_tick(rc_tick),
    .main_tick(main_tick), .external_wake_pin_n(external_wake_pin_n)
  );

  always #50 ref_clk = ~ref_clk;

  task automatic final_report;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe edge
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd_reg(a, d);
    chk(d, exp);
  endtask

  task automatic irq_pulse;
    @(posedge ref_clk);
    irq_pending <= 1'b1;
    @(posedge ref_clk);
    irq_pending <= 1'b0;
    cyc(2);
  endtask

  task automatic wait_lvl(input logic lvl, output int n);
    n = 0;
    while (sys_reset !== lvl && n < 400) begin
      cyc(1);
      n++;
    end
  endtask

  // a fixed window sees the same pulse count whatever the phase
  task automatic count_en(input int len, output int c_cpu, output int c_per);
    c_cpu = 0;
    c_per = 0;
    repeat (len) begin
      cyc(1);
      if (cpu_clk_en === 1'b1) c_cpu++;
      if (periph_clk_en === 1'b1) c_per++;
    end
  endtask

  initial begin
    #(100 * 5000);
    num_errors++;
    final_report();
  end

  initial begin
    int n;
    int cc;
    int pc;
    logic [7:0] st;
    logic seen_rst;
    ref_clk = 1'b0;
    rst = 1'b1;
    {wake_req, main_slow, irq_pending, wr, rd} = 5'h00;
    addr = 4'h0;
    wdata = 8'h00;
    num_errors = 0;
    num_checks = 0;
    cyc(8);
    chk({6'h00, clk_sel_rc, sys_reset}, 8'h03);
    @(posedge ref_clk);
    rst <= 1'b0;
    wait_lvl(1'b0, n);
    chk({7'h00, (n >= STAB && n < 400)}, 8'h01);
    cyc(2);
    chk({5'h00, clk_sel_rc, cpu_clk_en, periph_clk_en}, 8'h03);
    rd_chk(OSP_POWER_CONTROL_REGISTER_ADDR, OSP_POWER_CONTROL_REGISTER_RESET);
    wr_reg(OSP_STATUS_ADDR, 8'hFF);
    wr_reg(4'hF, 8'hFF);
    rd_chk(4'hF, 8'h00);
    rd_chk(OSP_STATUS_ADDR, 8'h04);
    wr_reg(OSP_POWER_CONTROL_REGISTER_ADDR, 8'h01);
    cyc(3);
    chk({6'h00, cpu_clk_en, periph_clk_en}, 8'h01);
    irq_pulse();
    rd_chk(OSP_POWER_CONTROL_REGISTER_ADDR, 8'h00);
    chk({7'h00, cpu_clk_en}, 8'h01);
    wr_reg(OSP_POWER_CONTROL_REGISTER_ADDR, 8'h10);
    cyc(2);
    count_en(64, cc, pc);
    chk({cc[3:0], pc[3:0]}, 8'h22);
    wr_reg(OSP_POWER_CONTROL_REGISTER_ADDR, 8'h11);
    cyc(2);
    count_en(64, cc, pc);
    chk({cc[3:0], pc[3:0]}, 8'h02);
    irq_pulse();
    rd_chk(OSP_POWER_CONTROL_REGISTER_ADDR, 8'h10);
    wr_reg(OSP_POWER_CONTROL_REGISTER_ADDR, 8'h10 & OSP_SLOW_CLR);
    cyc(2);
    count_en(8, cc, pc);
    chk({cc[3:0], pc[3:0]}, 8'h88);
    wr_reg(OSP_POWER_CONTROL_REGISTER_ADDR, 8'h22);
    cyc(4);
    chk({6'h00, rc_osc_run, main_osc_run}, 8'h00);
    irq_pulse();
    rd_chk(OSP_POWER_CONTROL_REGISTER_ADDR, 8'h22);
    rd_reg(OSP_STATUS_ADDR, st);
    chk(st & 8'h0A, 8'h08);
    @(posedge ref_clk);
    wake_req <= 1'b1;
    repeat (2) @(posedge ref_clk);
    wake_req <= 1'b0;
    rd_chk(OSP_STATUS_ADDR, 8'h11);
    n = 0;
    seen_rst = 1'b0;
    while (wake_irq !== 1'b1 && n < 400) begin
      cyc(1);
      n++;
      if (sys_reset === 1'b1) seen_rst = 1'b1;
    end
    chk({6'h00, seen_rst, (n >= STAB && n < 400)}, 8'h01);
    chk({6'h00, rc_osc_run, main_osc_run}, 8'h03);
    rd_chk(OSP_POWER_CONTROL_REGISTER_ADDR, 8'h20);
    @(posedge ref_clk);
    main_slow <= 1'b1;
    wait_lvl(1'b1, n);
    chk({6'h00, sys_reset, clk_sel_rc}, 8'h03);
    wr_reg(OSP_POWER_CONTROL_REGISTER_ADDR, 8'h10);
    rd_chk(OSP_POWER_CONTROL_REGISTER_ADDR, 8'h00);
    @(posedge ref_clk);
    main_slow <= 1'b0;
    wait_lvl(1'b0, n);
    cyc(1);
    chk({5'h00, sys_reset, clk_sel_rc, (n >= STAB && n < 400)}, 8'h01);
    final_report();
  end
endmodule
